/* File: logic/dac_common_regs.sv */
// common control and trigger register group of the quad output converter
// =====================================================================
`timescale 1ns/1ps
module dac_common_regs #(
    parameter int NCH = 4
) (
    input wire logic clk,
    input wire logic rstn,

    // register bus, one strobe per access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_paged,
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,

    // memory image and channel side
    input wire logic nvm_load_valid,
    input wire logic [15:0] nvm_load_data,
    input wire logic [NCH-1:0] sync_update_cfg,
    input wire logic [NCH-1:0] clear_level_select,
    input wire logic [NCH-1:0] cmp_raw,
    input wire logic [NCH-1:0] win_raw,
    output logic [NCH-1:0] cmp_flag,
    output logic [NCH-1:0] win_flag,

    // config levels
    output logic window_latch_enable,
    output logic register_lock,
    output logic dump_read_location,
    output logic internal_ref_enable,
    output logic [2*NCH-1:0] voltage_output_powerdown,
    output logic [NCH-1:0] current_output_powerdown,

    // one-cycle trigger pulses
    output logic soft_reset_pulse,
    output logic [NCH-1:0] load_trigger,
    output logic [NCH-1:0] clear_trigger,
    output logic [NCH-1:0] clear_to_mid,
    output logic fault_dump_start,
    output logic protect_start,
    output logic single_row_read_trigger,
    output logic memory_program_trigger,
    output logic memory_reload_trigger,

    // per-channel triggers, function start is a level
    output logic [NCH-1:0] comparator_flag_reset,
    output logic [NCH-1:0] margin_low_trigger,
    output logic [NCH-1:0] margin_high_trigger,
    output logic [NCH-1:0] function_start
);
    // the register layout has room for exactly four channels
    if (NCH != 4) begin : g_bad_nch
        $error("dac_common_regs supports NCH = 4 only");
    end

    // the channel nibbles must fill the trigger word exactly
    if (dac_regs_pkg::CHT_NIBBLE * NCH != dac_regs_pkg::CHT_TOP + 1) begin : g_bad_nib
        $error("channel nibbles do not fill the trigger word");
    end

    // =====================================================================
    // state
    typedef struct packed {
        // held fields
        logic [15:0] cfg;
        logic [3:0] password;
        logic [NCH-1:0] func;

        // bus answer; data held until the next read, valid follows the read strobe one cycle later
        logic [15:0] rdata;
        logic rvalid;

        // pulses, cleared every cycle so nothing fires twice
        logic swrst;
        logic [NCH-1:0] load;
        logic [NCH-1:0] clr;
        logic [NCH-1:0] clr_mid;
        logic fdump;
        logic protect;
        logic rowread;
        logic prog;
        logic reload;
        logic [NCH-1:0] cmp_rst;
        logic [NCH-1:0] mar_lo;
        logic [NCH-1:0] mar_hi;
    } regs_s;

    regs_s st_r;
    regs_s st_nxt;
    dac_regs_pkg::reg_sel_e sel;

    cmp_flag_if #(.NCH(NCH)) flags ();

    // =====================================================================
    // helpers
    function automatic int nib_bit(input int ch, input int pos);
        nib_bit = dac_regs_pkg::CHT_TOP - dac_regs_pkg::CHT_NIBBLE * ch
            - (dac_regs_pkg::CHT_NIBBLE - 1) + pos;
    endfunction

    function automatic int cfg_bit(input int ch, input int ofs);
        cfg_bit = dac_regs_pkg::CFG_CH_STRIDE * ch + ofs;
    endfunction

    // =====================================================================
    // submodules
    reg_addr_map u_map (
        .paged(reg_paged),
        .page(reg_page),
        .addr(reg_addr),
        .sel(sel)
    );

    cmp_flag_latch #(.NCH(NCH)) u_flags (
        .clk(clk),
        .rstn(rstn),
        .fl(flags)
    );

    assign flags.latch_en = st_r.cfg[dac_regs_pkg::CFG_WIN_LATCH];
    assign flags.flag_clr = st_r.cmp_rst;
    assign flags.cmp_raw = cmp_raw;
    assign flags.win_raw = win_raw;

    // =====================================================================
    // next state
    always_comb begin
        logic locked;
        logic [15:0] rd;
        locked = st_r.cfg[dac_regs_pkg::CFG_LOCK];
        rd = dac_regs_pkg::UNMAPPED_READ;
        st_nxt = st_r;
        // trigger outputs last one cycle; nothing holds them, so they read 0
        st_nxt.swrst = 1'b0;
        st_nxt.load = '0;
        st_nxt.clr = '0;
        st_nxt.clr_mid = '0;
        st_nxt.fdump = 1'b0;
        st_nxt.protect = 1'b0;
        st_nxt.rowread = 1'b0;
        st_nxt.prog = 1'b0;
        st_nxt.reload = 1'b0;
        st_nxt.cmp_rst = '0;
        st_nxt.mar_lo = '0;
        st_nxt.mar_hi = '0;
        st_nxt.rvalid = reg_rd;

        // reloaded memory image lands in the register map
        if (nvm_load_valid) begin
            st_nxt.cfg = nvm_load_data;
        end

        if (reg_wr) begin
            case (sel)
                dac_regs_pkg::SEL_CFG: begin
                    if (!locked) begin
                        st_nxt.cfg = reg_wdata;
                    end else if (!reg_wdata[dac_regs_pkg::CFG_LOCK]
                                 && st_r.password == dac_regs_pkg::UNLOCK_CODE) begin
                        // only the lock bit moves; the password is spent
                        st_nxt.cfg[dac_regs_pkg::CFG_LOCK] = 1'b0;
                        st_nxt.password = '0;
                    end
                end
                dac_regs_pkg::SEL_TRIG: begin
                    st_nxt.password = reg_wdata[dac_regs_pkg::TRG_PWD_LSB +: 4];
                    if (!locked) begin
                        st_nxt.fdump = reg_wdata[dac_regs_pkg::TRG_FDUMP];
                        st_nxt.protect = reg_wdata[dac_regs_pkg::TRG_PROTECT];
                        st_nxt.rowread = reg_wdata[dac_regs_pkg::TRG_ROWREAD];
                        st_nxt.prog = reg_wdata[dac_regs_pkg::TRG_PROG];
                        st_nxt.reload = reg_wdata[dac_regs_pkg::TRG_RELOAD];
                        if (reg_wdata[dac_regs_pkg::TRG_LOAD]) begin
                            st_nxt.load = sync_update_cfg;
                        end
                        if (reg_wdata[dac_regs_pkg::TRG_CLEAR]) begin
                            st_nxt.clr = '1;
                            st_nxt.clr_mid = clear_level_select;
                        end
                        if (reg_wdata[dac_regs_pkg::TRG_SWRST_LSB +: 4]
                            == dac_regs_pkg::SWRST_CODE) begin
                            // everything but the bus answer and the comparator flags back to power-on values, pulse only
                            st_nxt = '0;
                            st_nxt.cfg = dac_regs_pkg::CFG_RESET;
                            st_nxt.rvalid = reg_rd;
                            st_nxt.swrst = 1'b1;
                        end
                    end
                end
                dac_regs_pkg::SEL_CHTRIG: begin
                    if (!locked) begin
                        for (int c = 0; c < NCH; c++) begin
                            st_nxt.cmp_rst[c] = reg_wdata[nib_bit(c, dac_regs_pkg::CHT_CMP_RST)];
                            st_nxt.mar_lo[c] = reg_wdata[nib_bit(c, dac_regs_pkg::CHT_MAR_LO)];
                            st_nxt.mar_hi[c] = reg_wdata[nib_bit(c, dac_regs_pkg::CHT_MAR_HI)];
                            st_nxt.func[c] = reg_wdata[nib_bit(c, dac_regs_pkg::CHT_FUNC)];
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // read data is sampled from the state before this cycle's write
        case (sel)
            dac_regs_pkg::SEL_CFG: rd = st_r.cfg;
            dac_regs_pkg::SEL_TRIG: begin
                rd = dac_regs_pkg::TRIG_RESET;
                rd[dac_regs_pkg::TRG_PWD_LSB +: 4] = st_r.password;
            end
            dac_regs_pkg::SEL_CHTRIG: begin
                rd = dac_regs_pkg::CHTRIG_RESET;
                for (int c = 0; c < NCH; c++) begin
                    rd[nib_bit(c, dac_regs_pkg::CHT_FUNC)] = st_r.func[c];
                end
            end
            default: rd = dac_regs_pkg::UNMAPPED_READ;
        endcase
        st_nxt.rdata = reg_rd ? rd : st_r.rdata;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.cfg <= dac_regs_pkg::CFG_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =====================================================================
    // outputs, all straight from state flops
    assign reg_rdata = st_r.rdata;
    assign reg_rvalid = st_r.rvalid;
    assign cmp_flag = flags.cmp_flag;
    assign win_flag = flags.win_flag;
    assign window_latch_enable = st_r.cfg[dac_regs_pkg::CFG_WIN_LATCH];
    assign register_lock = st_r.cfg[dac_regs_pkg::CFG_LOCK];
    assign dump_read_location = st_r.cfg[dac_regs_pkg::CFG_DUMP_LOC];
    assign internal_ref_enable = st_r.cfg[dac_regs_pkg::CFG_INT_REF];
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            voltage_output_powerdown[2*c +: 2] =
                st_r.cfg[cfg_bit(c, dac_regs_pkg::CFG_VOUT_OFS) +: 2];
            current_output_powerdown[c] =
                st_r.cfg[cfg_bit(c, dac_regs_pkg::CFG_IOUT_OFS)];
        end
    end

    // =====================================================================
    // trigger pulses and channel levels
    assign soft_reset_pulse = st_r.swrst;
    assign load_trigger = st_r.load;
    assign clear_trigger = st_r.clr;
    assign clear_to_mid = st_r.clr_mid;
    assign fault_dump_start = st_r.fdump;
    assign protect_start = st_r.protect;
    assign single_row_read_trigger = st_r.rowread;
    assign memory_program_trigger = st_r.prog;
    assign memory_reload_trigger = st_r.reload;
    assign comparator_flag_reset = st_r.cmp_rst;
    assign margin_low_trigger = st_r.mar_lo;
    assign margin_high_trigger = st_r.mar_hi;
    assign function_start = st_r.func;
endmodule

/* File: logic/dac_regs_pkg.sv */
// constants, field layout and types of the common control register group
package dac_regs_pkg;

    // =====================================================================
    // register addresses, direct and paged
    localparam logic [7:0] ADDR_CFG = 8'h1F;
    localparam logic [7:0] ADDR_TRIG = 8'h20;
    localparam logic [7:0] ADDR_CHTRIG = 8'h21;
    localparam logic [7:0] PM_PAGE_COMMON = 8'hFF;
    localparam logic [7:0] PM_CODE_CFG = 8'hE3;
    localparam logic [7:0] PM_CODE_TRIG = 8'hE4;
    localparam logic [7:0] PM_CODE_CHTRIG = 8'hE5;

    // =====================================================================
    // reset values
    localparam logic [15:0] CFG_RESET = 16'h0FFF;
    localparam logic [15:0] TRIG_RESET = 16'h0000;
    localparam logic [15:0] CHTRIG_RESET = 16'h0000;
    localparam logic [15:0] UNMAPPED_READ = 16'h0000;

    // =====================================================================
    // shared_output_config fields
    localparam int CFG_WIN_LATCH = 15;
    localparam int CFG_LOCK = 14;
    localparam int CFG_DUMP_LOC = 13;
    localparam int CFG_INT_REF = 12;
    localparam int CFG_CH_STRIDE = 3;
    localparam int CFG_IOUT_OFS = 0;
    localparam int CFG_VOUT_OFS = 1;

    // =====================================================================
    // global_action_triggers fields
    localparam int TRG_PWD_LSB = 12;
    localparam int TRG_SWRST_LSB = 8;
    localparam int TRG_LOAD = 7;
    localparam int TRG_CLEAR = 6;
    localparam int TRG_FDUMP = 4;
    localparam int TRG_PROTECT = 3;
    localparam int TRG_ROWREAD = 2;
    localparam int TRG_PROG = 1;
    localparam int TRG_RELOAD = 0;
    localparam logic [3:0] UNLOCK_CODE = 4'h5;
    localparam logic [3:0] SWRST_CODE = 4'hA;

    // =====================================================================
    // channel_action_triggers nibble layout, channel 0 in the top nibble
    localparam int CHT_NIBBLE = 4;
    localparam int CHT_TOP = 15;
    localparam int CHT_CMP_RST = 3;
    localparam int CHT_MAR_LO = 2;
    localparam int CHT_MAR_HI = 1;
    localparam int CHT_FUNC = 0;

    // =====================================================================
    // power-down encodings
    localparam logic [1:0] VOUT_UP = 2'h0;
    localparam logic [1:0] VOUT_PD_10K = 2'h1;
    localparam logic [1:0] VOUT_PD_100K = 2'h2;
    localparam logic [1:0] VOUT_PD_HIZ = 2'h3;

    typedef enum logic [1:0] {
        SEL_NONE = 2'h0,
        SEL_CFG = 2'h1,
        SEL_TRIG = 2'h3,
        SEL_CHTRIG = 2'h2
    } reg_sel_e;

endpackage

/* File: logic/cmp_flag_if.sv */
// comparator flag signals between the register bank and the flag latches
`timescale 1ns/1ps
interface cmp_flag_if #(
    parameter int NCH = 4
);
    logic latch_en;
    logic [NCH-1:0] flag_clr;
    logic [NCH-1:0] cmp_raw;
    logic [NCH-1:0] win_raw;
    logic [NCH-1:0] cmp_flag;
    logic [NCH-1:0] win_flag;

    modport ctrl (
        output latch_en,
        output flag_clr,
        output cmp_raw,
        output win_raw,
        input cmp_flag,
        input win_flag
    );
    modport latch (
        input latch_en,
        input flag_clr,
        input cmp_raw,
        input win_raw,
        output cmp_flag,
        output win_flag
    );
endinterface

/* File: logic/reg_addr_map.sv */
// maps a direct address or a paged code onto one of the three registers
`timescale 1ns/1ps
module reg_addr_map (
    input wire logic paged,
    input wire logic [7:0] page,
    input wire logic [7:0] addr,
    output dac_regs_pkg::reg_sel_e sel
);
    // =====================================================================
    // decode
    always_comb begin
        sel = dac_regs_pkg::SEL_NONE;
        if (!paged) begin
            case (addr)
                dac_regs_pkg::ADDR_CFG: sel = dac_regs_pkg::SEL_CFG;
                dac_regs_pkg::ADDR_TRIG: sel = dac_regs_pkg::SEL_TRIG;
                dac_regs_pkg::ADDR_CHTRIG: sel = dac_regs_pkg::SEL_CHTRIG;
                default: sel = dac_regs_pkg::SEL_NONE;
            endcase
        end else if (page == dac_regs_pkg::PM_PAGE_COMMON) begin
            case (addr)
                dac_regs_pkg::PM_CODE_CFG: sel = dac_regs_pkg::SEL_CFG;
                dac_regs_pkg::PM_CODE_TRIG: sel = dac_regs_pkg::SEL_TRIG;
                dac_regs_pkg::PM_CODE_CHTRIG: sel = dac_regs_pkg::SEL_CHTRIG;
                default: sel = dac_regs_pkg::SEL_NONE;
            endcase
        end
    end
endmodule

/* File: logic/cmp_flag_latch.sv */
// latching and window comparator flags with per-channel clear
`timescale 1ns/1ps
module cmp_flag_latch #(
    parameter int NCH = 4
) (
    input wire logic clk,
    input wire logic rstn,
    cmp_flag_if.latch fl
);
    typedef struct packed {
        logic [NCH-1:0] cmp;
        logic [NCH-1:0] win;
    } latch_s;

    latch_s st_r;
    latch_s st_nxt;

    // =====================================================================
    // flags; a new trip in the clearing cycle is kept, set wins
    always_comb begin
        st_nxt.cmp = (st_r.cmp & ~fl.flag_clr) | fl.cmp_raw;
        if (fl.latch_en) begin
            st_nxt.win = (st_r.win & ~fl.flag_clr) | fl.win_raw;
        end else begin
            st_nxt.win = fl.win_raw;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fl.cmp_flag = st_r.cmp;
    assign fl.win_flag = st_r.win;
endmodule

/* File: bench/chan_side_model.sv */
// far-side model: comparator sources and per-channel function settings
`timescale 1ns/1ps
module chan_side_model #(
    parameter logic [3:0] SYNC = 4'h5,
    parameter logic [3:0] MID = 4'h3
) (
    input wire logic rstn,
    input wire logic [3:0] blip,
    output logic [3:0] cmp_raw,
    output logic [3:0] win_raw,
    output logic [3:0] sync_update_cfg,
    output logic [3:0] clear_level_select
);
    // =====================================================================
    // sources held low in reset so no flag can latch before release
    assign cmp_raw = rstn ? blip : 4'h0;
    assign win_raw = rstn ? blip : 4'h0;
    assign sync_update_cfg = SYNC;
    assign clear_level_select = MID;
endmodule

/* File: bench/dac_regs_checker.sv */
// assertion checker for the common control register group
`timescale 1ns/1ps
module dac_regs_checker #(
    parameter int NCH = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic reg_paged,
    input wire logic [7:0] reg_page,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic nvm_load_valid,
    input wire logic [NCH-1:0] sync_update_cfg,
    input wire logic [NCH-1:0] clear_level_select,
    input wire logic [NCH-1:0] win_raw,
    input wire logic [NCH-1:0] win_flag,
    input wire logic window_latch_enable,
    input wire logic register_lock,
    input wire logic [2*NCH-1:0] voltage_output_powerdown,
    input wire logic [NCH-1:0] current_output_powerdown,
    input wire logic soft_reset_pulse,
    input wire logic [NCH-1:0] load_trigger,
    input wire logic [NCH-1:0] clear_trigger,
    input wire logic [NCH-1:0] clear_to_mid,
    input wire logic fault_dump_start,
    input wire logic [NCH-1:0] margin_low_trigger,
    input wire logic [NCH-1:0] function_start
);
    // =====================================================================
    // decode helpers; channel 0 sits in the top nibble
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic wr_cfg, wr_trig, wr_ch, go;
    logic [3:0] lo_w, fn_w;
    assign wr_cfg = reg_wr && (reg_paged ? reg_page == 8'hFF && reg_addr == 8'hE3
                                         : reg_addr == 8'h1F);
    assign wr_trig = reg_wr && (reg_paged ? reg_page == 8'hFF && reg_addr == 8'hE4
                                          : reg_addr == 8'h20);
    assign wr_ch = reg_wr && (reg_paged ? reg_page == 8'hFF && reg_addr == 8'hE5
                                        : reg_addr == 8'h21);
    assign go = wr_trig && !register_lock && reg_wdata[11:8] != 4'hA;
    assign lo_w = {reg_wdata[2], reg_wdata[6], reg_wdata[10], reg_wdata[14]};
    assign fn_w = {reg_wdata[0], reg_wdata[4], reg_wdata[8], reg_wdata[12]};

    // =====================================================================
    // properties
    sequence s_soft_pulse;
        soft_reset_pulse && load_trigger == 4'h0 ##1 !soft_reset_pulse;
    endsequence
    property p_reset; $rose(rstn) |-> voltage_output_powerdown == 8'hFF
        && current_output_powerdown == 4'hF && !register_lock; endproperty
    property p_soft; wr_trig && !register_lock && reg_wdata[11:8] == 4'hA
        |=> s_soft_pulse; endproperty
    property p_load; go && reg_wdata[7] |=> load_trigger == $past(sync_update_cfg);
    endproperty
    property p_clear; go && reg_wdata[6] |=> clear_trigger == 4'hF
        && clear_to_mid == $past(clear_level_select); endproperty
    property p_fdump; $rose(fault_dump_start) |-> $past(go && reg_wdata[4]); endproperty
    property p_lock; register_lock && wr_cfg && !nvm_load_valid
        |=> $stable(voltage_output_powerdown) && (register_lock || !$past(reg_wdata[14]));
    endproperty
    property p_chan; wr_ch && !register_lock |=> margin_low_trigger == $past(lo_w)
        && function_start == $past(fn_w); endproperty
    property p_win; $past(rstn) && $past(!window_latch_enable) && !window_latch_enable
        |-> win_flag == $past(win_raw); endproperty

    a_reset: assert property (p_reset) else $error("reset values wrong");
    a_soft: assert property (p_soft) else $error("soft reset pulse wrong");
    a_load: assert property (p_load) else $error("load pulse wrong");
    a_clear: assert property (p_clear) else $error("clear pulse wrong");
    a_fdump: assert property (p_fdump) else $error("dump start without write");
    a_lock: assert property (p_lock) else $error("locked config changed");
    a_chan: assert property (p_chan) else $error("channel trigger wrong");
    a_win: assert property (p_win) else $error("window flag not following");
endmodule

bind dac_common_regs dac_regs_checker #(.NCH(NCH)) chk (.clk, .rstn, .reg_wr, .reg_paged,
    .reg_page, .reg_addr, .reg_wdata, .nvm_load_valid, .sync_update_cfg, .clear_level_select,
    .win_raw, .win_flag, .window_latch_enable, .register_lock, .voltage_output_powerdown,
    .current_output_powerdown, .soft_reset_pulse, .load_trigger, .clear_trigger,
    .clear_to_mid, .fault_dump_start, .margin_low_trigger, .function_start);

/* File: bench/testbench.sv */
// self-checking bench for the common control register group
`timescale 1ns/1ps
module testbench;
    // =====================================================================
    // signals
    logic clk, rstn, reg_wr, reg_rd, reg_paged, nvm_load_valid, reg_rvalid;
    logic [7:0] reg_page, reg_addr, voltage_output_powerdown;
    logic [15:0] reg_wdata, nvm_load_data, reg_rdata, exp;
    logic soft_reset_pulse, fault_dump_start, protect_start, single_row_read_trigger;
    logic memory_program_trigger, memory_reload_trigger, window_latch_enable;
    logic register_lock, dump_read_location, internal_ref_enable;
    logic [3:0] blip, cmp_raw, win_raw, sync_update_cfg, clear_level_select, cmp_flag;
    logic [3:0] win_flag, current_output_powerdown, load_trigger, clear_trigger;
    logic [3:0] clear_to_mid, comparator_flag_reset, margin_low_trigger;
    logic [3:0] margin_high_trigger, function_start;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    int tbit[7] = '{7, 6, 4, 3, 2, 1, 0};

    dac_common_regs #(.NCH(4)) uut (.clk, .rstn, .reg_wr, .reg_rd, .reg_paged, .reg_page,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .nvm_load_valid, .nvm_load_data,
        .sync_update_cfg, .clear_level_select, .cmp_raw, .win_raw, .cmp_flag, .win_flag,
        .window_latch_enable, .register_lock, .dump_read_location, .internal_ref_enable,
        .voltage_output_powerdown, .current_output_powerdown, .soft_reset_pulse,
        .load_trigger, .clear_trigger, .clear_to_mid, .fault_dump_start, .protect_start,
        .single_row_read_trigger, .memory_program_trigger, .memory_reload_trigger,
        .comparator_flag_reset, .margin_low_trigger, .margin_high_trigger, .function_start);
    chan_side_model far (.rstn, .blip, .cmp_raw, .win_raw, .sync_update_cfg,
        .clear_level_select);

    // =====================================================================
    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // =====================================================================
    // access tasks; inputs move on the falling edge, away from sampling
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        num_checks++;
        if (got !== want) begin
            n_mismatch++;
            $display("ERROR %0t got %h expected %h", $time, got, want);
        end
    endtask
    task automatic wr(input logic p, input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_paged = p;
        reg_page = 8'hFF;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic p, input logic [7:0] pg, input logic [7:0] a,
                      input logic [15:0] want);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_paged = p;
        reg_page = pg;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk({15'h0, reg_rvalid}, 16'h0001);
        chk(reg_rdata, want);
    endtask
    task automatic pulse_sources();
        blip = 4'hF;
        @(negedge clk);
        blip = 4'h0;
        repeat (2) @(negedge clk);
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] cfg_out();
        return {window_latch_enable, register_lock, dump_read_location, internal_ref_enable,
                current_output_powerdown, voltage_output_powerdown};
    endfunction
    function automatic logic [15:0] obs();
        return {load_trigger, clear_trigger, 3'h0, fault_dump_start, protect_start,
                single_row_read_trigger, memory_program_trigger, memory_reload_trigger};
    endfunction

    // =====================================================================
    // test sequence
    initial begin
        {rstn, reg_wr, reg_rd, reg_paged, nvm_load_valid} = 5'h00;
        {reg_page, reg_addr, reg_wdata, nvm_load_data, blip} = 52'h0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        chk(cfg_out(), 16'h0FFF);
        rd(0, 8'hFF, 8'h1F, 16'h0FFF);
        rd(0, 8'hFF, 8'h21, 16'h0000);
        // latch on, dump at 0x01, reference on, mixed power-down codes
        wr(0, 8'h1F, 16'hB1E3);
        chk(cfg_out(), 16'hB539);
        rd(1, 8'hFF, 8'hE3, 16'hB1E3);
        foreach (tbit[i]) begin
            wr(i[0], i[0] ? 8'hE4 : 8'h20, 16'h1 << tbit[i]);
            exp = tbit[i] == 7 ? 16'h5000 : tbit[i] == 6 ? 16'h0F00 : 16'h1 << tbit[i];
            chk(obs(), exp);
            if (tbit[i] == 6) chk({12'h0, clear_to_mid}, 16'h0003);
            rd(0, 8'hFF, 8'h20, 16'h0000);
        end
        pulse_sources();
        chk({8'h0, cmp_flag, win_flag}, 16'h00FF);
        wr(1, 8'hE5, 16'h8421);
        chk({comparator_flag_reset, margin_low_trigger, margin_high_trigger, function_start},
            16'h1248);
        @(negedge clk);
        chk({8'h0, cmp_flag, win_flag}, 16'h00EE);
        rd(0, 8'hFF, 8'h21, 16'h0001);
        wr(0, 8'h21, 16'h9888);
        @(negedge clk);
        chk({4'h0, cmp_flag, win_flag, function_start}, 16'h0001);
        wr(0, 8'h1F, 16'h31E3);
        pulse_sources();
        chk({12'h0, win_flag}, 16'h0000);
        // lock, then try to unlock without and with the right password
        wr(0, 8'h1F, 16'h4FFF);
        wr(0, 8'h1F, 16'h0000);
        rd(0, 8'hFF, 8'h1F, 16'h4FFF);
        wr(0, 8'h21, 16'h0000);
        chk({12'h0, function_start}, 16'h0001);
        wr(0, 8'h20, 16'h3080);
        chk(obs(), 16'h0000);
        rd(0, 8'hFF, 8'h20, 16'h3000);
        wr(0, 8'h1F, 16'h0000);
        chk({15'h0, register_lock}, 16'h0001);
        wr(1, 8'hE4, 16'h5000);
        wr(0, 8'h1F, 16'h0000);
        chk(cfg_out(), 16'h0FFF);
        rd(0, 8'hFF, 8'h20, 16'h0000);
        // software reset: wrong code first, then the real one
        wr(0, 8'h1F, 16'hB1E3);
        wr(0, 8'h20, 16'h0B00);
        chk({15'h0, soft_reset_pulse}, 16'h0000);
        chk(cfg_out(), 16'hB539);
        wr(0, 8'h20, 16'h0AFF);
        chk({15'h0, soft_reset_pulse}, 16'h0001);
        chk(obs(), 16'h0000);
        @(negedge clk);
        chk(cfg_out(), 16'h0FFF);
        chk({12'h0, function_start}, 16'h0000);
        // unmapped places and the wrong page
        wr(0, 8'h22, 16'hFFFF);
        rd(0, 8'hFF, 8'h22, 16'h0000);
        rd(1, 8'h00, 8'hE3, 16'h0000);
        rd(1, 8'hFF, 8'hE3, 16'h0FFF);
        nvm_load_valid = 1'b1;
        nvm_load_data = 16'h1234;
        @(negedge clk);
        nvm_load_valid = 1'b0;
        rd(0, 8'hFF, 8'h1F, 16'h1234);
        tally_and_finish();
    end
endmodule
